// file: mmi_mgmt.sv
`timescale 1ns/100ps
// ==========================================================================
// How it works
// - Clause 22 frames, station supplies clock.
// - Answer only frames matching strapped address.
// - Channel select bit picks channel A or B.
// - Dual write bit updates both channels.
// - Bad or read-only writes change nothing.
// - Invalid register reads return zeros.
// - Data window reaches addressed extended register.
// - Read-write bits keep the written value.
// - Self-clearing bits pulse once, read zero.
// - Sticky-high status clears when read.
// - Sticky-low status sets when read.
// - Counter clears on read, saturates, ignores writes.
// - Half-speed mode samples each bit twice.
// - Reference input chosen by register or pins.
// - Byte clock is line rate over twenty.
// - Half-VCO clock is VCO over two.
// - Clock outputs pick source and ratio.
// - Global reset self-clears next cycle.
module mmi_mgmt
  import mmi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] strapped_port_address,
  input wire logic [1:0] refclk_sel_pins,
  input wire logic ref_clock_input_zero,
  input wire logic ref_clock_input_one,
  input wire logic [1:0] link_fault,
  input wire logic [1:0] link_up,
  input wire logic [1:0] code_error,
  input wire logic [1:0] ls_serial_in,
  output logic [1:0] ls_oversampled,
  output logic [1:0] ls_sample_valid,
  output logic [1:0] ref_clock_chan,
  output logic [1:0] recovered_byte_clock,
  output logic [1:0] half_vco_clock,
  output logic clock_output_a,
  output logic clock_output_b,
  output logic datapath_reset,
  output logic [15:0] hs_ctl_a,
  output logic [15:0] hs_ctl_b,
  output logic [15:0] ext_ctl
);
  typedef enum logic [2:0] {MMI_IDLE, MMI_HDR, MMI_TA, MMI_RDATA, MMI_WDATA} mmi_state_e;

  mmi_state_e st_q;
  logic mdc_q;
  logic mdc_rise;
  logic [5:0] bits_q;
  logic [13:0] hdr_q;
  logic [15:0] sh_q;
  logic match_q;
  logic [15:0] global_q;
  logic [15:0] clkout_q;
  logic [15:0] iaddr_q;
  logic [15:0] speed_q;
  logic [1:0] lh_q;
  logic [1:0] ll_q;
  logic [7:0] cnt_q;
  logic rd_done;
  logic wr_done;
  logic [4:0] reg_a;
  logic soft_rst;
  logic rst_all;
  logic [1:0] ovs_q;
  logic [4:0] rbc_cnt_q [2];
  logic [1:0] vco_q;
  logic [1:0] clk_src;

  assign soft_rst = global_q[MMI_BIT_GRESET];
  assign rst_all = sys_rst | soft_rst;
  assign mdc_rise = mdc & ~mdc_q;
  assign reg_a = hdr_q[4:0];

  // Register read mux; invalid addresses give zero.
  function automatic logic [15:0] rd_val(input logic [4:0] a);
    unique case (a)
      MMI_REG_GLOBAL: rd_val = global_q & MMI_GLOBAL_RMASK;
      MMI_REG_STATUS: rd_val = {14'h0000, ll_q[0], lh_q[0]};
      MMI_REG_ERRCNT: rd_val = {8'h00, cnt_q};
      MMI_REG_HSCTL: rd_val = global_q[MMI_BIT_MACRO] ? hs_ctl_b : hs_ctl_a;
      MMI_REG_CLKOUT: rd_val = clkout_q;
      MMI_REG_IND_ADDR: rd_val = iaddr_q;
      MMI_REG_IND_DATA: begin
        if (iaddr_q == MMI_EXT_CTL) begin
          rd_val = ext_ctl;
        end else if (iaddr_q == MMI_EXT_SPEED) begin
          rd_val = speed_q;
        end else begin
          rd_val = 16'h0000;
        end
      end
      default: rd_val = 16'h0000;
    endcase
  endfunction

  // ==========================================================================
  // Frame engine
  always_ff @(posedge sys_clk) begin
    mdc_q <= mdc;
  end

  assign rd_done = mdc_rise && st_q == MMI_RDATA && bits_q == MMI_DATA_BITS - 6'h01;
  assign wr_done = mdc_rise && st_q == MMI_WDATA && bits_q == MMI_DATA_BITS - 6'h01 && match_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= MMI_IDLE;
      bits_q <= 6'h00;
      hdr_q <= 14'h0000;
      sh_q <= 16'h0000;
      match_q <= 1'b0;
    end else if (mdc_rise) begin
      unique case (st_q)
        MMI_IDLE: begin
          bits_q <= mdio_in ? (bits_q == MMI_PREAMBLE_BITS ? bits_q : bits_q + 6'h01) : 6'h00;
          if (!mdio_in && bits_q == MMI_PREAMBLE_BITS) begin
            st_q <= MMI_HDR;
            bits_q <= 6'h01;
            hdr_q <= 14'h0000;
          end
        end
        MMI_HDR: begin
          hdr_q <= {hdr_q[12:0], mdio_in};
          bits_q <= bits_q + 6'h01;
          if (bits_q == MMI_HDR_BITS - 6'h01) begin
            bits_q <= 6'h00;
            match_q <= hdr_q[8:4] == strapped_port_address && hdr_q[11] == MMI_ST_START[0];
            st_q <= MMI_TA;
          end
        end
        MMI_TA: begin
          bits_q <= bits_q + 6'h01;
          if (bits_q == MMI_TA_BITS - 6'h01) begin
            bits_q <= 6'h00;
            sh_q <= rd_val(reg_a);
            st_q <= hdr_q[11:10] == MMI_OP_READ && match_q ? MMI_RDATA : MMI_WDATA;
          end
        end
        MMI_RDATA: begin
          sh_q <= {sh_q[14:0], 1'b0};
          bits_q <= bits_q + 6'h01;
          if (rd_done) begin
            st_q <= MMI_IDLE;
            bits_q <= 6'h00;
          end
        end
        MMI_WDATA: begin
          sh_q <= {sh_q[14:0], mdio_in};
          bits_q <= bits_q + 6'h01;
          if (bits_q == MMI_DATA_BITS - 6'h01) begin
            st_q <= MMI_IDLE;
            bits_q <= 6'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
    end else begin
      mdio_oe <= st_q == MMI_RDATA && !rd_done;
      mdio_out <= st_q == MMI_RDATA ? sh_q[15] : 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  logic wr_ok;
  logic [15:0] wdata;
  logic wr_hs;
  assign wdata = {sh_q[14:0], mdio_in};
  // writes need a match and a write opcode
  assign wr_ok = wr_done && hdr_q[11:10] == MMI_OP_WRITE;
  assign wr_hs = wr_ok && reg_a == MMI_REG_HSCTL;

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      global_q <= MMI_GLOBAL_RST;
      clkout_q <= 16'h0000;
      iaddr_q <= 16'h0000;
      ext_ctl <= 16'h0000;
      speed_q <= 16'h0000;
    end else if (wr_ok) begin
      unique case (reg_a)
        MMI_REG_GLOBAL: global_q <= (wdata & MMI_GLOBAL_WMASK) | (wdata & 16'h8000);
        MMI_REG_CLKOUT: clkout_q <= wdata;
        MMI_REG_IND_ADDR: iaddr_q <= wdata;
        MMI_REG_IND_DATA: begin
          if (iaddr_q == MMI_EXT_CTL) begin
            ext_ctl <= wdata;
          end else if (iaddr_q == MMI_EXT_SPEED) begin
            speed_q <= wdata;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    datapath_reset <= rst_all;
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      hs_ctl_a <= 16'h0000;
      hs_ctl_b <= 16'h0000;
    end else if (wr_hs) begin
      if (global_q[MMI_BIT_GWRITE] || !global_q[MMI_BIT_MACRO]) begin
        hs_ctl_a <= wdata;
      end
      if (global_q[MMI_BIT_GWRITE] || global_q[MMI_BIT_MACRO]) begin
        hs_ctl_b <= wdata;
      end
    end
  end

  // ==========================================================================
  // Status: a new event wins over the read (clear for sticky-high, set for sticky-low).
  logic rd_stat;
  logic rd_cnt;
  assign rd_stat = rd_done && match_q && reg_a == MMI_REG_STATUS;
  assign rd_cnt = rd_done && match_q && reg_a == MMI_REG_ERRCNT;

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      lh_q <= 2'b00;
      ll_q <= 2'b11;
    end else begin
      lh_q[0] <= link_fault[0] | link_fault[1] | (lh_q[0] & ~rd_stat);
      ll_q[0] <= (link_up[0] & link_up[1]) & (ll_q[0] | rd_stat);
      lh_q[1] <= 1'b0;
      ll_q[1] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      cnt_q <= 8'h00;
    end else if (rd_cnt) begin
      cnt_q <= |code_error ? 8'h01 : 8'h00;
    end else if (|code_error && cnt_q != MMI_CNT_MAX) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ==========================================================================
  // Clocking
  // double sampling in half-speed mode
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      ovs_q <= 2'b00;
      ls_oversampled <= 2'b00;
      ls_sample_valid <= 2'b00;
    end else begin
      ovs_q <= ls_serial_in;
      ls_oversampled <= speed_q[0] ? (ovs_q & ls_serial_in) | (ovs_q & ls_oversampled) : ls_serial_in;
      ls_sample_valid <= speed_q[0] ? ~ls_sample_valid : 2'b11;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      ref_clock_chan[c] <= (global_q[c + MMI_BIT_REFSEL] | refclk_sel_pins[c]) ? ref_clock_input_one : ref_clock_input_zero;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (rst_all) begin
        rbc_cnt_q[c] <= 5'h00;
        recovered_byte_clock[c] <= 1'b0;
        vco_q[c] <= 1'b0;
      end else begin
        vco_q[c] <= ~vco_q[c];
        if (rbc_cnt_q[c] == 5'(MMI_HS_LINE_DIV) - 5'h01) begin
          rbc_cnt_q[c] <= 5'h00;
          recovered_byte_clock[c] <= ~recovered_byte_clock[c];
        end else begin
          rbc_cnt_q[c] <= rbc_cnt_q[c] + 5'h01;
        end
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    half_vco_clock <= vco_q;
  end

  assign clk_src = clkout_q[MMI_CLK_SRC_BIT] ? half_vco_clock : recovered_byte_clock;
  logic div_a;
  logic div_b;
  mmi_clkdiv u_div_a (
    .sys_clk(sys_clk),
    .sys_rst(rst_all),
    .src_in(clk_src[0]),
    .ratio_sel(clkout_q[3:0]),
    .clk_out_q(div_a)
  );
  mmi_clkdiv u_div_b (
    .sys_clk(sys_clk),
    .sys_rst(rst_all),
    .src_in(clk_src[1]),
    .ratio_sel(clkout_q[11:8]),
    .clk_out_q(div_b)
  );
  always_ff @(posedge sys_clk) begin
    clock_output_a <= clkout_q[3:0] == 4'h0 ? clk_src[0] : div_a;
    clock_output_b <= clkout_q[11:8] == 4'h0 ? clk_src[1] : div_b;
  end
endmodule

// file: mmi_pkg.sv
// ==========================================================================
// Register map and frame layout of the management slave.
package mmi_pkg;
  localparam logic [4:0] MMI_REG_GLOBAL = 5'h00;
  localparam logic [4:0] MMI_REG_CLKOUT = 5'h15;
  localparam logic [4:0] MMI_REG_STATUS = 5'h01;
  localparam logic [4:0] MMI_REG_ERRCNT = 5'h02;
  localparam logic [4:0] MMI_REG_HSCTL = 5'h10;
  localparam logic [4:0] MMI_REG_IND_ADDR = 5'h1E;
  localparam logic [4:0] MMI_REG_IND_DATA = 5'h1F;
  localparam logic [15:0] MMI_EXT_BASE = 16'h8000;
  localparam logic [15:0] MMI_EXT_CTL = 16'h8000;
  localparam logic [15:0] MMI_EXT_SPEED = 16'h8001;
  localparam logic [15:0] MMI_GLOBAL_RST = 16'h0610;
  localparam logic [15:0] MMI_GLOBAL_WMASK = 16'h1FFF;
  localparam logic [15:0] MMI_GLOBAL_RMASK = 16'h1F9F;
  localparam int MMI_BIT_REFSEL = 5;
  localparam int MMI_BIT_GRESET = 15;
  localparam int MMI_BIT_MACRO = 12;
  localparam int MMI_BIT_GWRITE = 11;
  localparam int MMI_BIT_LH = 0;
  localparam int MMI_BIT_LL = 1;
  localparam int MMI_CLK_SRC_BIT = 4;
  localparam logic [1:0] MMI_ST_START = 2'b01;
  localparam logic [1:0] MMI_OP_WRITE = 2'b01;
  localparam logic [1:0] MMI_OP_READ = 2'b10;
  localparam logic [5:0] MMI_PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] MMI_HDR_BITS = 6'h0E;
  localparam logic [5:0] MMI_TA_BITS = 6'h02;
  localparam logic [5:0] MMI_DATA_BITS = 6'h10;
  localparam logic [7:0] MMI_CNT_MAX = 8'hFF;
  localparam logic [3:0] MMI_HS_LINE_DIV = 4'hA;
endpackage

// file: mmi_clkdiv.sv
`timescale 1ns/100ps
// ==========================================================================
// Programmable divider used for each clock output.
module mmi_clkdiv
  import mmi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic src_in,
  input wire logic [3:0] ratio_sel,
  output logic clk_out_q
);
  logic [4:0] cnt_q;
  logic [4:0] half_d;
  logic [4:0] full_d;
  logic src_q;
  logic src_rise;

  assign src_rise = src_in & ~src_q;

  always_ff @(posedge sys_clk) begin
    src_q <= src_in;
  end

  always_comb begin
    unique case (ratio_sel)
      4'h0: full_d = 5'h01;
      4'h1: full_d = 5'h02;
      4'h2: full_d = 5'h04;
      4'h3: full_d = 5'h05;
      4'h4: full_d = 5'h08;
      4'h5: full_d = 5'h0A;
      4'h6: full_d = 5'h10;
      4'h7: full_d = 5'h14;
      4'h8: full_d = 5'h19;
      default: full_d = 5'h01;
    endcase
    half_d = full_d >> 1;
  end

  // Source rises are counted, not system clocks, so the ratio applies to the chosen clock.
  // The count is cut at or above the end point, so a ratio change never lets it wrap.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= 5'h00;
      clk_out_q <= 1'b0;
    end else if (full_d == 5'h01) begin
      cnt_q <= 5'h00;
      clk_out_q <= src_in;
    end else if (src_rise) begin
      if (cnt_q >= full_d - 5'h01) begin
        cnt_q <= 5'h00;
        clk_out_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q + 5'h01 == half_d) begin
          clk_out_q <= 1'b1;
        end
      end
    end
  end
endmodule

// file: mmi_mgmt_assertions.sv
`timescale 1ns/100ps
// ==========================================================================
// Port checks for the management slave.
module mmi_mgmt_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [1:0] refclk_sel_pins,
  input wire logic ref_clock_input_one,
  input wire logic [1:0] ref_clock_chan,
  input wire logic datapath_reset,
  input wire logic [15:0] hs_ctl_a,
  input wire logic [15:0] hs_ctl_b,
  input wire logic [15:0] ext_ctl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_oe_after_reset: assert property ($fell(sys_rst) |-> !mdio_oe)
    else $error("data line driven right after reset");
  a_dp_after_reset: assert property ($fell(sys_rst) |-> datapath_reset)
    else $error("datapath reset missing after reset");
  a_dp_one_cycle: assert property (datapath_reset |=> !datapath_reset)
    else $error("datapath reset longer than one cycle");
  a_ctla_at_mdc: assert property ($changed(hs_ctl_a) |-> mdc || datapath_reset)
    else $error("channel A control changed outside a frame");
  a_ctlb_at_mdc: assert property ($changed(hs_ctl_b) |-> mdc || datapath_reset)
    else $error("channel B control changed outside a frame");
  a_ext_at_mdc: assert property ($changed(ext_ctl) |-> mdc || datapath_reset)
    else $error("extended control changed outside a frame");
  a_oe_rise_mdc: assert property ($rose(mdio_oe) |-> mdc)
    else $error("drive began away from a clock rise");
  a_oe_hold: assert property ($rose(mdio_oe) |=> mdio_oe [*8])
    else $error("read drive dropped too early");
  a_out_at_mdc: assert property (mdio_oe && $changed(mdio_out) |-> mdc)
    else $error("read data changed away from a clock rise");
  a_ref_by_pin: assert property (refclk_sel_pins[0] |=> ref_clock_chan[0] == $past(ref_clock_input_one))
    else $error("pin select did not pick reference one");
  c_read: cover property ($rose(mdio_oe));
  c_greset: cover property ($rose(datapath_reset));
  c_ext: cover property ($changed(ext_ctl));
endmodule
bind mmi_mgmt mmi_mgmt_chk chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .refclk_sel_pins(refclk_sel_pins), .ref_clock_input_one(ref_clock_input_one),
  .ref_clock_chan(ref_clock_chan), .datapath_reset(datapath_reset), .hs_ctl_a(hs_ctl_a),
  .hs_ctl_b(hs_ctl_b), .ext_ctl(ext_ctl));

// file: mmi_station.sv
`timescale 1ns/100ps
// ==========================================================================
// Station controller: owns the slow clock, which stands low between frames.
module mmi_station
  import mmi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic mdio,
  output logic mdc,
  output logic st_d,
  output logic st_oe
);
  initial begin
    mdc = 1'b0;
    st_d = 1'b1;
    st_oe = 1'b0;
  end
  // one bit per slow clock, sampled just before the rise.
  task automatic bit_x(input logic b, input logic drv, output logic s);
    st_oe = drv;
    st_d = b;
    repeat (6) @(negedge sys_clk);
    s = mdio;
    mdc = 1'b1;
    repeat (6) @(negedge sys_clk);
    mdc = 1'b0;
  endtask
  // preamble, header, turnaround released on reads, then data.
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [15:0] h;
    logic s;
    h = {MMI_ST_START, op, pa, ra, 2'b10};
    repeat (32) bit_x(1'b1, 1'b1, s);
    for (int i = 15; i >= 0; i--) bit_x(h[i], op == MMI_OP_WRITE || i > 1, s);
    for (int i = 15; i >= 0; i--) begin
      bit_x(wd[i], op == MMI_OP_WRITE, s);
      rd[i] = s;
    end
    st_oe = 1'b0;
    @(negedge sys_clk);
  endtask
endmodule

// file: mmi_mgmt_test.sv
`timescale 1ns/100ps
// ==========================================================================
// Bench for the management slave.
module mmi_mgmt_test;
  import mmi_pkg::*;
  localparam logic [4:0] PA = 5'h0B;
  logic sys_clk, sys_rst, mdc, mdio, mdio_out, mdio_oe, st_d, st_oe, datapath_reset;
  logic ref_clock_input_zero, ref_clock_input_one;
  logic [1:0] refclk_sel_pins, link_fault, link_up, code_error, ls_serial_in;
  logic [15:0] hs_ctl_a, hs_ctl_b, ext_ctl, v;
  logic [1:0] ls_oversampled, ls_sample_valid, ref_clock_chan, recovered_byte_clock, half_vco_clock;
  logic clock_output_a, clock_output_b;
  logic [3:0] ck;
  int fail_count, tests_run, ha, hb;
  assign ck = {clock_output_b, clock_output_a, half_vco_clock[0], recovered_byte_clock[0]};
  // The line has a pull-up, so a released line reads as ones.
  assign mdio = mdio_oe ? mdio_out : (st_oe ? st_d : 1'b1);
  mmi_station st_u (.sys_clk(sys_clk), .mdio(mdio), .mdc(mdc), .st_d(st_d), .st_oe(st_oe));
  mmi_mgmt dut_u (.*, .mdio_in(mdio), .strapped_port_address(PA));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    {refclk_sel_pins, ref_clock_input_zero, ref_clock_input_one, ls_serial_in} <= sys_rst ? 6'h00 : 6'($urandom);
  end
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] r;
    st_u.xfer(MMI_OP_READ, pa, ra, 16'h0000, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] r;
    st_u.xfer(MMI_OP_WRITE, pa, ra, d, r);
  endtask
  task automatic err_pulse();
    @(negedge sys_clk) code_error = 2'b01;
    @(negedge sys_clk) code_error = 2'b00;
  endtask
  // Skips the half period in progress, then counts the next one in system clocks.
  task automatic half_period(input int k, input int e);
    logic x;
    int n;
    for (int p = 0; p < 2; p++) begin
      x = ck[k];
      n = 0;
      while (ck[k] === x && n < 64) begin
        @(negedge sys_clk);
        n++;
      end
    end
    chk(16'(n), 16'(e));
  endtask
  initial begin
    #1000000;
    fail_count++;
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    link_fault = 2'b00;
    link_up = 2'b11;
    code_error = 2'b00;
    void'($urandom(77));
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(PA, MMI_REG_GLOBAL, MMI_GLOBAL_RST);
    @(negedge sys_clk) {link_fault, link_up} = 4'h6;
    @(negedge sys_clk) {link_fault, link_up} = 4'h3;
    rd(PA, MMI_REG_STATUS, 16'h0001);
    rd(PA, MMI_REG_STATUS, 16'h0002);
    repeat (5) err_pulse();
    wr(PA, MMI_REG_ERRCNT, 16'h0033);
    rd(PA, MMI_REG_ERRCNT, 16'h0005);
    rd(PA, MMI_REG_ERRCNT, 16'h0000);
    repeat (300) err_pulse();
    rd(PA, MMI_REG_ERRCNT, 16'(MMI_CNT_MAX));
    v = 16'($urandom);
    wr(PA, MMI_REG_CLKOUT, v);
    wr(PA + 5'h01, MMI_REG_CLKOUT, ~v);
    wr(PA, 5'h07, ~v);
    rd(PA, MMI_REG_CLKOUT, v);
    rd(PA, 5'h07, 16'h0000);
    rd(PA + 5'h01, MMI_REG_GLOBAL, 16'hFFFF);
    wr(PA, MMI_REG_CLKOUT, 16'h0011);
    half_period(0, 10);
    half_period(1, 1);
    half_period(2, 2);
    half_period(3, 1);
    wr(PA, MMI_REG_GLOBAL, 16'h0670);
    rd(PA, MMI_REG_GLOBAL, MMI_GLOBAL_RST);
    repeat (4) begin
      @(negedge sys_clk);
      chk(16'(ref_clock_chan), 16'({2{ref_clock_input_one}}));
    end
    for (int m = 0; m < 3; m++) begin
      v = 16'($urandom);
      wr(PA, MMI_REG_GLOBAL, {3'b000, m == 2, m == 0, 11'h610});
      wr(PA, MMI_REG_HSCTL, v);
      if (m != 2) ha = v;
      if (m != 1) hb = v;
      chk(hs_ctl_a, ha[15:0]);
      chk(hs_ctl_b, hb[15:0]);
    end
    v = 16'($urandom);
    wr(PA, MMI_REG_IND_ADDR, MMI_EXT_CTL);
    wr(PA, MMI_REG_IND_DATA, v);
    chk(ext_ctl, v);
    rd(PA, MMI_REG_IND_DATA, v);
    wr(PA, MMI_REG_IND_ADDR, MMI_EXT_SPEED);
    repeat (4) begin
      @(negedge sys_clk);
      chk(16'(ls_sample_valid), 16'h0003);
      chk(16'(ls_oversampled), 16'(ls_serial_in));
    end
    wr(PA, MMI_REG_IND_DATA, 16'h0001);
    @(negedge sys_clk);
    v = 16'(ls_sample_valid);
    @(negedge sys_clk);
    chk(16'(ls_sample_valid), v ^ 16'h0003);
    wr(PA, MMI_REG_GLOBAL, 16'h8610);
    rd(PA, MMI_REG_GLOBAL, MMI_GLOBAL_RST);
    half_period(2, 10);
    test_done();
  end
endmodule
